// File: pkg/atc_consts.svh
// constants of the actuator teach-in controller
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH
`define ATC_CLK_NS        50
`define ATC_TICK_MS       125
`define ATC_TICK_CYC      ((`ATC_TICK_MS * 1000000) / `ATC_CLK_NS)
`define ATC_TEACH_MS      60000
`define ATC_TEACH_TICKS   (`ATC_TEACH_MS / `ATC_TICK_MS)
`define ATC_MAX_TEACH     4'h8
`define ATC_SELF_BLINKS   4'h3
`define ATC_BLINK_ON      4'h2
`define ATC_BLINK_LEN     4'h4
`define ATC_BURST_PAUSE   4'h8
`define ATC_KIND_NINTH    2'h1
`define ATC_KIND_OLD      2'h2
`define ATC_KIND_NACK     2'h3
`define ATC_REG_CTRL      8'h00
`define ATC_REG_STATUS    8'h04
`define ATC_REG_CODE      8'h08
`define ATC_CTRL_INHIBIT  0
`endif

// File: pkg/atc_pkg.sv
// types shared by the teach-in controller and its lamp blinker
package atc_pkg;
  typedef enum logic [2:0] {
    ATC_ST_LOAD  = 3'b000,
    ATC_ST_SELF  = 3'b001,
    ATC_ST_FACT  = 3'b010,
    ATC_ST_RUN   = 3'b011,
    ATC_ST_TEACH = 3'b100,
    ATC_ST_ACK   = 3'b101,
    ATC_ST_OPF   = 3'b110,
    ATC_ST_FAULT = 3'b111
  } atc_state_e;

  typedef enum logic [2:0] {
    ATC_BL_OFF   = 3'b000,
    ATC_BL_ON    = 3'b001,
    ATC_BL_FAST  = 3'b010,
    ATC_BL_SLOW  = 3'b011,
    ATC_BL_BURST = 3'b100,
    ATC_BL_ONCE  = 3'b101
  } atc_blink_e;
endpackage

// File: hdl/atc_blink.sv
// time base prescaler and green lamp pattern generator
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_blink
  import atc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `ATC_TICK_CYC
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // pattern request
  input  atc_blink_e      mode_i,
  input  wire logic [1:0] count_i,
  // results
  output logic            tick_o,
  output logic            done_o,
  output logic            led_o
);
  typedef struct packed {
    logic [31:0] pre;
    logic        tick;
    logic [3:0]  ph;
    logic [1:0]  n;
    logic        led;
    logic        done;
    atc_blink_e  mode;
  } atc_bl_s;

  atc_bl_s r;
  atc_bl_s next_r;

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.tick = (r.pre == TICK_CYC - 1);
    next_r.pre  = next_r.tick ? 32'h0 : r.pre + 32'h1;
    next_r.mode = mode_i;
    if (mode_i != r.mode)
    begin
      // restart phase and count so a new pattern starts at its first phase; the prescaler keeps running
      next_r.ph  = 4'h0;
      next_r.n   = 2'h0;
      next_r.led = (mode_i == ATC_BL_ON);
    end
    else
    begin
      case (mode_i)
        ATC_BL_OFF: next_r.led = 1'b0;
        ATC_BL_ON:  next_r.led = 1'b1;
        ATC_BL_FAST:
        begin
          if (r.tick)
            next_r.led = ~r.led;
        end
        ATC_BL_SLOW:
        begin
          if (r.tick)
          begin
            next_r.ph = (r.ph == `ATC_BLINK_LEN - 4'h1) ? 4'h0 : r.ph + 4'h1;
            if (r.ph == `ATC_BLINK_LEN - 4'h1)
              next_r.led = ~r.led;
          end
        end
        ATC_BL_BURST, ATC_BL_ONCE:
        begin
          if (r.n < count_i)
          begin
            next_r.led = (r.ph < `ATC_BLINK_ON);
            if (r.tick)
            begin
              next_r.ph = (r.ph == `ATC_BLINK_LEN - 4'h1) ? 4'h0 : r.ph + 4'h1;
              if (r.ph == `ATC_BLINK_LEN - 4'h1)
                next_r.n = r.n + 2'h1;
            end
          end
          else
          begin
            next_r.led = 1'b0;
            if (r.tick)
            begin
              next_r.ph = r.ph + 4'h1;
              if (r.ph == `ATC_BURST_PAUSE - 4'h1)
              begin
                next_r.ph   = 4'h0;
                next_r.n    = 2'h0;
                next_r.done = 1'b1;
              end
            end
          end
        end
        default: next_r.led = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick_o = r.tick;
  assign done_o = r.done;
  assign led_o  = r.led;
endmodule

// File: hdl/atc_ctrl.sv
// actuator teach-in controller: detection, teach-in sequence, safety outputs and lamps
// Summary of operation
// - teach-in keeps safety and door outputs off
// - door change or power loss in teach-in: fault, lamps
// - at most eight teach-ins, counted persistently
// - only the last taught code is valid
// - untaught actuator never reported as detected
// - power-up green blinks show remaining teach-ins, up to three
// - ninth or old actuator: teach, store nothing
// - factory state blinks green at 4 Hz
// - door closed, new actuator: teach, 1 Hz
// - after 60 s teach, green lamp off
// - activation stores code, retires old actuator
// - self-test blinks up to three, then steady, or 4 Hz in factory state
// - closed with valid actuator: green, yellow on
// - open guard: green steady, others off
// - red lamp on internal or teach fault
// - actuator leaves early: negative acknowledge, red
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_ctrl
  import atc_pkg::*;
#(
  parameter int unsigned CODE_W   = 16,
  parameter int unsigned TICK_CYC = `ATC_TICK_CYC
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // read head and door
  input  wire logic              door_closed_i,
  input  wire logic              act_present_i,
  input  wire logic [CODE_W-1:0] act_code_i,
  input  wire logic              internal_fault_i,
  input  wire logic              power_fail_i,
  // non-volatile store image read at power-up
  input  wire logic [3:0]        nv_count_i,
  input  wire logic [CODE_W-1:0] nv_act_code_i,
  input  wire logic [CODE_W-1:0] nv_old_code_i,
  input  wire logic              nv_pend_i,
  input  wire logic [CODE_W-1:0] nv_pend_code_i,
  // non-volatile store update
  output logic                   nv_we_o,
  output logic [3:0]             nv_count_o,
  output logic [CODE_W-1:0]      nv_act_code_o,
  output logic [CODE_W-1:0]      nv_old_code_o,
  output logic                   nv_pend_o,
  output logic [CODE_W-1:0]      nv_pend_code_o,
  // register port
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  // safety outputs and lamps
  output logic                   safety_output_a_o,
  output logic                   safety_output_b_o,
  output logic                   door_monitor_o,
  output logic                   led_green_o,
  output logic                   led_yellow_o,
  output logic                   led_red_o
);
  typedef struct packed {
    atc_state_e        st;
    logic [3:0]        count;
    logic [CODE_W-1:0] act;
    logic [CODE_W-1:0] old;
    logic [CODE_W-1:0] pcode;
    logic              pend;
    logic [CODE_W-1:0] tcode;
    logic              store;
    logic [1:0]        kind;
    logic [9:0]        timer;
    logic              inhibit;
    logic              we;
    logic              out;
    logic              yellow;
    logic              red;
    logic [31:0]       rdata;
  } atc_ctrl_s;

  atc_ctrl_s  r;
  atc_ctrl_s  next_r;
  logic [1:0] rst_sync;
  logic       rst_n;
  logic       tick;
  logic       blink_done;
  atc_blink_e green_mode;
  logic [1:0] green_cnt;
  logic [3:0] remain;
  logic       match;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // only the active code counts; any other code is not a detection
  assign match  = act_present_i && (act_code_i == r.act) && (r.count != 4'h0);
  assign remain = `ATC_MAX_TEACH - r.count;

  always_comb
  begin
    green_mode = ATC_BL_OFF;
    green_cnt  = 2'h0;
    case (r.st)
      ATC_ST_SELF:
      begin
        green_mode = ATC_BL_ONCE;
        green_cnt  = (remain > `ATC_SELF_BLINKS) ? 2'h3 : remain[1:0];
      end
      ATC_ST_FACT:  green_mode = ATC_BL_FAST;
      ATC_ST_RUN:   green_mode = ATC_BL_ON;
      ATC_ST_TEACH: green_mode = ATC_BL_SLOW;
      ATC_ST_ACK:   green_mode = ATC_BL_OFF;
      ATC_ST_OPF:
      begin
        green_mode = ATC_BL_BURST;
        green_cnt  = r.kind;
      end
      default:      green_mode = ATC_BL_OFF;
    endcase
  end

  always_comb
  begin
    next_r       = r;
    next_r.we    = 1'b0;
    next_r.rdata = 32'h0;
    if (wr_i && addr_i == `ATC_REG_CTRL)
      next_r.inhibit = wdata_i[`ATC_CTRL_INHIBIT];
    if (rd_i)
    begin
      case (addr_i)
        `ATC_REG_CTRL:   next_r.rdata = {31'h0, r.inhibit};
        `ATC_REG_STATUS: next_r.rdata = {20'h0, r.pend, r.kind, r.count, r.st, 1'b0, r.out};
        `ATC_REG_CODE:   next_r.rdata = 32'(r.act);
        default:         next_r.rdata = 32'h0;
      endcase
    end
    case (r.st)
      ATC_ST_LOAD:
      begin
        next_r.count = nv_count_i;
        next_r.act   = nv_act_code_i;
        next_r.old   = nv_old_code_i;
        next_r.pcode = nv_pend_code_i;
        next_r.pend  = 1'b0;
        if (nv_pend_i)
        begin
          // activation after the power cycle: new code in, old one retired
          next_r.act = nv_pend_code_i;
          next_r.old = nv_act_code_i;
          next_r.we  = 1'b1;
        end
        next_r.st = ATC_ST_SELF;
      end
      ATC_ST_SELF:
      begin
        if (blink_done)
          next_r.st = (r.count == 4'h0) ? ATC_ST_FACT : ATC_ST_RUN;
      end
      ATC_ST_FACT, ATC_ST_RUN:
      begin
        next_r.timer = 10'h0;
        next_r.tcode = act_code_i;
        if (door_closed_i && act_present_i && !(r.st == ATC_ST_RUN && act_code_i == r.act))
        begin
          next_r.st    = ATC_ST_TEACH;
          next_r.store = 1'b1;
          next_r.kind  = 2'h0;
          if (r.count != 4'h0 && act_code_i == r.old)
          begin
            next_r.store = 1'b0;
            next_r.kind  = `ATC_KIND_OLD;
          end
          else if (r.count >= `ATC_MAX_TEACH)
          begin
            next_r.store = 1'b0;
            next_r.kind  = `ATC_KIND_NINTH;
          end
        end
      end
      ATC_ST_TEACH:
      begin
        if (!door_closed_i || power_fail_i)
        begin
          next_r.st   = ATC_ST_OPF;
          next_r.kind = `ATC_KIND_NACK;
        end
        else if (!act_present_i || act_code_i != r.tcode)
        begin
          next_r.st   = ATC_ST_OPF;
          next_r.kind = `ATC_KIND_NACK;
        end
        else if (r.timer == 10'(`ATC_TEACH_TICKS))
        begin
          if (r.store)
          begin
            next_r.st    = ATC_ST_ACK;
            next_r.pend  = 1'b1;
            next_r.pcode = r.tcode;
            next_r.count = r.count + 4'h1;
            next_r.we    = 1'b1;
          end
          else
            next_r.st = ATC_ST_OPF;
        end
        else if (tick)
          next_r.timer = r.timer + 10'h1;
      end
      ATC_ST_ACK:
      begin
        // left only by removing power or by an internal fault; the new code waits for the power cycle
        next_r.st = ATC_ST_ACK;
      end
      ATC_ST_OPF:
      begin
        if (!door_closed_i && !act_present_i)
          next_r.st = (r.count == 4'h0) ? ATC_ST_FACT : ATC_ST_RUN;
      end
      default: next_r.st = ATC_ST_FAULT;
    endcase
    if (internal_fault_i)
      next_r.st = ATC_ST_FAULT;
    // outputs follow the next state so that they line up with the state register
    next_r.out    = (next_r.st == ATC_ST_RUN) && door_closed_i && match && !r.inhibit;
    next_r.yellow = (next_r.st == ATC_ST_RUN) && door_closed_i && match;
    next_r.red    = (next_r.st == ATC_ST_OPF) || (next_r.st == ATC_ST_FAULT);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  atc_blink #(
    .TICK_CYC (TICK_CYC)
  ) u_blink (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .mode_i  (green_mode),
    .count_i (green_cnt),
    .tick_o  (tick),
    .done_o  (blink_done),
    .led_o   (led_green_o)
  );

  // both channels carry the same decision; the far side pulls the relay in only when both are on
  assign safety_output_a_o = r.out;
  assign safety_output_b_o = r.out;
  assign door_monitor_o    = r.out;
  assign led_yellow_o      = r.yellow;
  assign led_red_o         = r.red;
  assign rdata_o           = r.rdata;
  assign nv_we_o           = r.we;
  assign nv_count_o        = r.count;
  assign nv_act_code_o     = r.act;
  assign nv_old_code_o     = r.old;
  assign nv_pend_o         = r.pend;
  assign nv_pend_code_o    = r.pcode;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_teach_outputs_off: assert property (r.st == ATC_ST_TEACH |-> !safety_output_a_o && !door_monitor_o)
    else $error("safety output on during teach-in");
  chk_teach_abort_door: assert property (r.st == ATC_ST_TEACH && (!door_closed_i || power_fail_i)
                                         |=> r.st == ATC_ST_OPF && led_red_o)
    else $error("door change in teach-in did not fault");
  chk_count_limit: assert property (r.st != ATC_ST_LOAD |-> r.count <= `ATC_MAX_TEACH)
    else $error("teach-in count above limit");
  chk_valid_code_only: assert property (safety_output_a_o |-> $past(act_code_i) == r.act && $past(act_present_i))
    else $error("outputs on without the active code");
  chk_no_store_teach: assert property (r.st == ATC_ST_TEACH && !r.store |=> r.count == $past(r.count) && !r.pend)
    else $error("code stored on a refused teach-in");
  chk_ack_green_off: assert property ((r.st == ATC_ST_ACK) [*3] |-> !led_green_o)
    else $error("green lamp lit after acknowledge");
  chk_fault_red_lamp: assert property (r.st == ATC_ST_FAULT |-> led_red_o && !safety_output_b_o)
    else $error("fault without red lamp");
  chk_activate_code: assert property (r.st == ATC_ST_LOAD && nv_pend_i |=> r.act == $past(nv_pend_code_i)
                                      && r.old == $past(nv_act_code_i) && nv_we_o)
    else $error("pending code not activated");
  chk_early_leave: assert property (r.st == ATC_ST_TEACH && door_closed_i && !act_present_i
                                    |=> r.st == ATC_ST_OPF && r.kind == `ATC_KIND_NACK)
    else $error("early leave not refused");

  cov_teach_done: cover property (r.st == ATC_ST_TEACH ##1 r.st == ATC_ST_ACK);
  cov_op_fault:   cover property (r.st == ATC_ST_TEACH ##1 r.st == ATC_ST_OPF);
  cov_run_on:     cover property (safety_output_a_o && led_yellow_o);
  cov_power_fail: cover property (r.st == ATC_ST_TEACH && power_fail_i ##1 r.st == ATC_ST_OPF);
endmodule

// File: tb/atc_relay_model.sv
// far side model: safety relay with contactor feedback, plus the non-volatile store
`timescale 1ns/1ps
module atc_relay_model
#(
  parameter int unsigned CODE_W = 16
)
(
  // clock
  input  wire logic              clk_i,
  // from the controller
  input  wire logic              sa_i,
  input  wire logic              sb_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        cnt_i,
  input  wire logic [CODE_W-1:0] act_i,
  input  wire logic [CODE_W-1:0] old_i,
  input  wire logic              pend_i,
  input  wire logic [CODE_W-1:0] pcode_i,
  // store image and relay state
  output logic [3:0]             cnt_o,
  output logic [CODE_W-1:0]      act_o,
  output logic [CODE_W-1:0]      old_o,
  output logic                   pend_o,
  output logic [CODE_W-1:0]      pcode_o,
  output logic                   relay_o,
  output logic                   cont_err_o
);
  logic cont;
  logic miss;
  // the store survives resets; the bench presets it by hierarchical write
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      cnt_o   <= cnt_i;
      act_o   <= act_i;
      old_o   <= old_i;
      pend_o  <= pend_i;
      pcode_o <= pcode_i;
    end
  end
  // a single live channel never pulls the relay in
  always @(posedge clk_i)
  begin
    relay_o    <= sa_i & sb_i;
    cont       <= relay_o;
    miss       <= cont != relay_o;
    cont_err_o <= miss & (cont != relay_o);
  end
endmodule

// File: tb/atc_ctrl_tb_top.sv
// self-checking bench of the actuator teach-in controller
`timescale 1ns/1ps
`include "atc_consts.svh"
module atc_ctrl_tb_top;
  localparam int unsigned TC     = 4;
  localparam logic [15:0] CODE_A = 16'h5A3C;
  localparam logic [15:0] CODE_B = 16'hC3A5;
  logic        clk_i;
  logic        reset_n_i;
  logic        door, pres, fault, pfail, wr, rd, we, s_pend, w_pend;
  logic        sa, sb, dmon, grn, yel, red;
  logic [15:0] code, s_act, s_old, s_pcode, w_act, w_old, w_pcode;
  logic [3:0]  s_cnt, w_cnt;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  int          failures, compares;
  int          cycles = 0;

  atc_ctrl #(.CODE_W(16), .TICK_CYC(TC)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .door_closed_i(door), .act_present_i(pres),
    .act_code_i(code), .internal_fault_i(fault), .power_fail_i(pfail),
    .nv_count_i(s_cnt), .nv_act_code_i(s_act), .nv_old_code_i(s_old), .nv_pend_i(s_pend),
    .nv_pend_code_i(s_pcode), .nv_we_o(we), .nv_count_o(w_cnt), .nv_act_code_o(w_act),
    .nv_old_code_o(w_old), .nv_pend_o(w_pend), .nv_pend_code_o(w_pcode), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .safety_output_a_o(sa),
    .safety_output_b_o(sb), .door_monitor_o(dmon), .led_green_o(grn), .led_yellow_o(yel),
    .led_red_o(red));

  atc_relay_model #(.CODE_W(16)) m (
    .clk_i(clk_i), .sa_i(sa), .sb_i(sb), .we_i(we), .cnt_i(w_cnt), .act_i(w_act),
    .old_i(w_old), .pend_i(w_pend), .pcode_i(w_pcode), .cnt_o(s_cnt), .act_o(s_act),
    .old_o(s_old), .pend_o(s_pend), .pcode_o(s_pcode), .relay_o(), .cont_err_o());

  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a full run needs about 7000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic drive(input logic d, input logic p, input logic [15:0] c);
    @(posedge clk_i);
    door <= d;
    pres <= p;
    code <= c;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
    #1;
  endtask

  // store contents do not decay, so the off time is shortened to the reset hold
  task automatic power_up;
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wait_state(input logic [2:0] s, input int lim, output int n);
    logic [31:0] d;
    n = 0;
    d = 32'h0;
    while (d[4:2] !== s && n < 2 * lim)
    begin
      bus_rd(`ATC_REG_STATUS, d);
      n += 2;
    end
    chk("state", s, d[4:2]);
  endtask

  task automatic watch(input int n, output int tg, output logic on);
    logic g;
    tg = 0;
    on = 1'h0;
    g  = grn;
    repeat (n)
    begin
      step(1);
      if (grn !== g)
        tg++;
      g  = grn;
      on = on | sa | sb | dmon;
    end
  endtask

  task automatic t_factory;
    int   tg, n;
    logic on;
    wait_state(3'h2, 100, n);
    chk("lamps", 2'h0, {yel, red});
    watch(80, tg, on);
    chk("fast_blink", 1'h1, tg >= 19 && tg <= 21);
  endtask

  task automatic t_teach;
    int   tg, n1, n2;
    logic on;
    drive(1'h1, 1'h1, CODE_A);
    wait_state(3'h4, 10, n1);
    watch(160, tg, on);
    chk("slow_blink", 1'h1, tg >= 9 && tg <= 11);
    chk("outputs_on", 1'h0, on);
    wait_state(3'h5, 1100, n2);
    n1 = n1 + n2 + 160;
    chk("teach_len", 1'h1, n1 >= (`ATC_TEACH_TICKS - 1) * TC && n1 <= (`ATC_TEACH_TICKS + 3) * TC);
    chk("green_ack", 1'h0, grn);
    chk("store", {4'h1, 1'h1, CODE_A}, {m.cnt_o, m.pend_o, m.pcode_o});
  endtask

  task automatic t_activate;
    int          tg, n;
    logic        on;
    logic [31:0] d;
    drive(1'h0, 1'h0, CODE_A);
    power_up();
    watch(60, tg, on);
    chk("self_blinks", 6, tg);
    wait_state(3'h3, 60, n);
    chk("store", {CODE_A, 1'h0}, {m.act_o, m.pend_o});
    bus_rd(`ATC_REG_CODE, d);
    chk("code_reg", CODE_A, d);
    chk("run_lamps", 3'h4, {grn, yel, red});
    drive(1'h1, 1'h1, CODE_A);
    step(3);
    chk("closed", 5'h1F, {sa, sb, dmon, grn, yel});
    chk("relay", 2'h2, {m.relay_o, m.cont_err_o});
    bus_wr(`ATC_REG_CTRL, 32'h1);
    step(1);
    chk("inhibit", 3'h1, {sa, sb, yel});
    bus_wr(`ATC_REG_CTRL, 32'h0);
    bus_rd(8'h0C, d);
    chk("unmapped", 32'h0, d);
    drive(1'h0, 1'h0, CODE_A);
    step(3);
    chk("open_guard", 5'h10, {grn, yel, red, sa, dmon});
  endtask

  task automatic t_abort;
    int          n, tg;
    logic        on;
    logic [31:0] d;
    drive(1'h0, 1'h1, CODE_B);
    step(3);
    chk("untaught_seen", 1'h0, yel);
    drive(1'h1, 1'h1, CODE_B);
    wait_state(3'h4, 10, n);
    drive(1'h0, 1'h1, CODE_B);
    wait_state(3'h6, 5, n);
    bus_rd(`ATC_REG_STATUS, d);
    chk("abort_kind", 2'h3, d[10:9]);
    chk("abort_lamps", 3'h1, {sa, dmon, red});
    drive(1'h0, 1'h0, CODE_B);
    wait_state(3'h3, 10, n);
    chk("store_count", 4'h1, m.cnt_o);
    // actuator taken away while the door stays closed
    drive(1'h1, 1'h1, CODE_B);
    wait_state(3'h4, 10, n);
    drive(1'h1, 1'h0, CODE_B);
    wait_state(3'h6, 5, n);
    bus_rd(`ATC_REG_STATUS, d);
    chk("leave_kind", 2'h3, d[10:9]);
    chk("leave_lamps", 3'h1, {sa, dmon, red});
    drive(1'h0, 1'h0, CODE_B);
    wait_state(3'h3, 10, n);
    // supply warning in the middle of a teach-in
    drive(1'h1, 1'h1, CODE_B);
    wait_state(3'h4, 10, n);
    @(posedge clk_i);
    pfail <= 1'h1;
    wait_state(3'h6, 5, n);
    watch(60, tg, on);
    chk("fault_blinks", 1'h1, tg >= 5 && tg <= 6);
    chk("fault_outputs", 2'h1, {on, red});
    @(posedge clk_i);
    pfail <= 1'h0;
    drive(1'h0, 1'h0, CODE_B);
    wait_state(3'h3, 10, n);
    chk("store_count", 4'h1, m.cnt_o);
  endtask

  // old actuator or exhausted count: full teach time, nothing stored
  task automatic t_refused(input logic [3:0] cnt, input logic [15:0] old, input logic [1:0] kind);
    int          n;
    logic [31:0] d;
    drive(1'h0, 1'h0, CODE_B);
    m.cnt_o <= cnt;
    m.old_o <= old;
    power_up();
    wait_state(3'h3, 60, n);
    drive(1'h1, 1'h1, CODE_B);
    wait_state(3'h4, 10, n);
    wait_state(3'h6, 1100, n);
    chk("refused_len", 1'h1, n >= (`ATC_TEACH_TICKS - 2) * TC);
    bus_rd(`ATC_REG_STATUS, d);
    chk("refused_kind", kind, d[10:9]);
    chk("store", {cnt, 1'h0, CODE_A}, {m.cnt_o, m.pend_o, m.act_o});
    chk("refused_red", 2'h1, {sa, red});
  endtask

  task automatic t_fault;
    int n;
    @(posedge clk_i);
    fault <= 1'h1;
    step(3);
    chk("fault_lamps", 3'h1, {sa, sb, red});
    wait_state(3'h7, 3, n);
  endtask

  initial
  begin
    reset_n_i = 1'h0;
    door      = 1'h0;
    pres      = 1'h0;
    code      = 16'h0;
    fault     = 1'h0;
    pfail     = 1'h0;
    addr      = 8'h0;
    wdata     = 32'h0;
    wr        = 1'h0;
    rd        = 1'h0;
    failures  = 0;
    compares  = 0;
    m.cnt_o   = 4'h0;
    m.act_o   = 16'h0;
    m.old_o   = 16'h0;
    m.pend_o  = 1'h0;
    m.pcode_o = 16'h0;
    power_up();
    t_factory();
    t_teach();
    t_activate();
    t_abort();
    t_refused(4'h7, CODE_B, 2'h2);
    t_refused(4'h8, 16'h0001, 2'h1);
    t_fault();
    end_sim();
  end
endmodule
